// file: core/piezo_led_driver_control.sv
// Sequencing and output control for a piezo buzzer and LED driver
// How it works
// (R1) Oscillator resistor pin tied high selects external drive, tone taken from the tone input.
// (R2) Oscillator resistor pin pulled low selects self drive from the internal oscillator.
// (R3) In external drive the first rising tone edge from shutdown only turns the boost on.
// (R4) Disabled piezo outputs are both driven low.
// (R5) In external drive a steady high tone input keeps the boost on without enabling the piezo outputs.
// (R6) The second rising tone edge in external drive enables outputs, positive following tone.
// (R7) With outputs enabled the negative output is the inverse of the positive output.
// (R8) Both inputs mostly low for 15 ms puts the block into shutdown.
// (R9) In self drive a high tone input runs the oscillator onto the outputs, low stops it.
// (R10) The LED sink follows the LED control input, so PWM dims the LEDs.
// (R11) The boost stays on whenever the tone or the LED input is high.
// (R12) The host sends one power-up edge and then the tone as a square wave.
// (R13) Shutdown clears the edge sequencing so a new first edge is needed.
`timescale 1ns/10ps
`default_nettype none
module piezo_led_driver_control #(
    parameter int unsigned IDLE_CYCLES = piezo_pkg::IDLE_CYCLES,
    parameter int unsigned OSC_HALF    = piezo_pkg::OSC_HALF_DEFAULT
) (
    input  wire logic      clock_in,         // 100 MHz system clock
    input  wire logic      rst_n_in,         // Async reset, active low
    input  wire logic      tone_in,          // Tone / enable pin from host
    input  wire logic      led_ctrl_in,      // LED control pin from host
    input  wire logic      osc_resistor_pin_in, // High: external drive, low: self drive
    output logic           boost_en_out,     // Boost converter enable
    output logic           piezo_out_pos_out,// Positive piezo output
    output logic           piezo_out_neg_out,// Negative piezo output
    output logic           led_sink_pin_out, // LED current sink enable
    output logic           self_drive_out    // Mode in use, high for self drive
);
    // Synchronisers
    logic [1:0] tone_sync_q, led_sync_q, mode_sync_q;
    logic [1:0] tone_sync_d, led_sync_d, mode_sync_d;
    logic       tone_s, led_s, mode_ext;
    logic       tone_prev_q, tone_prev_d;

    always_comb begin
        tone_sync_d = {tone_sync_q[0], tone_in};
        led_sync_d  = {led_sync_q[0], led_ctrl_in};
        mode_sync_d = {mode_sync_q[0], osc_resistor_pin_in};
        tone_prev_d = tone_s;
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tone_sync_q <= piezo_pkg::SYNC_RESET;
            led_sync_q  <= piezo_pkg::SYNC_RESET;
            mode_sync_q <= piezo_pkg::SYNC_RESET;
            tone_prev_q <= 1'b0;
        end else begin
            tone_sync_q <= tone_sync_d;
            led_sync_q  <= led_sync_d;
            mode_sync_q <= mode_sync_d;
            tone_prev_q <= tone_prev_d;
        end
    end

    assign tone_s   = tone_sync_q[1];
    assign led_s    = led_sync_q[1];
    assign mode_ext = mode_sync_q[1]; // R1 R2

    logic tone_rise;
    assign tone_rise = tone_s & ~tone_prev_q;

    // Idle detection: majority of low samples over short windows, counted up to 15 ms
    logic [piezo_pkg::LOW_MAJ_W-1:0]  win_cnt_q, win_cnt_d, low_cnt_q, low_cnt_d;
    logic [piezo_pkg::IDLE_CNT_W-1:0] idle_cnt_q, idle_cnt_d;
    logic                             idle_q, idle_d;
    logic                             both_low;
    piezo_pkg::seq_state_e            state_q, state_d;

    assign both_low = ~tone_s & ~led_s;

    always_comb begin
        win_cnt_d  = win_cnt_q + 4'h1;
        low_cnt_d  = low_cnt_q + {3'h0, both_low};
        idle_cnt_d = idle_cnt_q;
        idle_d     = 1'b0;
        if (tone_s || led_s) begin
            idle_d = 1'b0; // R11
        end
        if (win_cnt_q == piezo_pkg::LOW_MAJ_WINDOW) begin
            win_cnt_d = '0;
            low_cnt_d = '0;
            if (low_cnt_q >= piezo_pkg::LOW_MAJ_THRESH) begin
                if (idle_cnt_q < piezo_pkg::IDLE_CNT_W'(IDLE_CYCLES)) begin
                    idle_cnt_d = idle_cnt_q + 21'h10;
                end
            end else begin
                idle_cnt_d = '0;
            end
        end
        if (idle_cnt_q >= piezo_pkg::IDLE_CNT_W'(IDLE_CYCLES)) begin
            idle_d = 1'b1; // R8
        end
        if (tone_rise || (led_s && state_q == piezo_pkg::ST_SHUTDOWN)) begin
            // Waking must clear a saturated idle count, or the boost drops again
            idle_cnt_d = '0;
            idle_d     = 1'b0; // R13
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            win_cnt_q  <= '0;
            low_cnt_q  <= '0;
            idle_cnt_q <= '0;
            idle_q     <= 1'b1;
        end else begin
            win_cnt_q  <= win_cnt_d;
            low_cnt_q  <= low_cnt_d;
            idle_cnt_q <= idle_cnt_d;
            idle_q     <= idle_d;
        end
    end

    // Sequencer

    always_comb begin
        state_d = state_q;
        case (state_q)
            piezo_pkg::ST_SHUTDOWN: begin
                if (tone_rise) begin
                    state_d = piezo_pkg::ST_BOOST; // R3
                end else if (led_s) begin
                    state_d = piezo_pkg::ST_BOOST; // R11
                end
            end
            piezo_pkg::ST_BOOST: begin
                if (idle_q && both_low) begin
                    state_d = piezo_pkg::ST_SHUTDOWN; // R8 R11 R13
                end else if (tone_rise && mode_ext) begin
                    state_d = piezo_pkg::ST_ACTIVE; // R6
                end
            end
            piezo_pkg::ST_ACTIVE: begin
                if (idle_q && both_low) begin
                    state_d = piezo_pkg::ST_SHUTDOWN; // R8 R11 R13
                end
            end
            default: state_d = piezo_pkg::ST_SHUTDOWN;
        endcase
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= piezo_pkg::ST_SHUTDOWN;
        end else begin
            state_q <= state_d;
        end
    end

    // Internal oscillator, runs only while tone is high in self drive
    logic [piezo_pkg::OSC_CNT_W-1:0] osc_cnt_q, osc_cnt_d;
    logic                            osc_q, osc_d;
    logic                            osc_run;

    assign osc_run = ~mode_ext & tone_s & (state_q != piezo_pkg::ST_SHUTDOWN); // R9

    always_comb begin
        osc_cnt_d = '0;
        osc_d     = 1'b0;
        if (osc_run) begin
            osc_d     = osc_q;
            osc_cnt_d = osc_cnt_q + 20'h1;
            if (osc_cnt_q >= piezo_pkg::OSC_CNT_W'(OSC_HALF - 1)) begin
                osc_cnt_d = '0;
                osc_d     = ~osc_q;
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            osc_cnt_q <= '0;
            osc_q     <= 1'b0;
        end else begin
            osc_cnt_q <= osc_cnt_d;
            osc_q     <= osc_d;
        end
    end

    // Output registers
    piezo_pkg::drive_s drv_q, drv_d;
    logic              enabled;

    always_comb begin
        enabled           = 1'b0;
        drv_d.boost_en    = (state_d != piezo_pkg::ST_SHUTDOWN); // R5 R11
        drv_d.led_sink_en = led_s; // R10
        drv_d.piezo_pos   = 1'b0; // R4
        drv_d.piezo_neg   = 1'b0; // R4
        if (mode_ext) begin
            enabled = (state_d == piezo_pkg::ST_ACTIVE);
            if (enabled) begin
                drv_d.piezo_pos = tone_s; // R1 R6
            end
        end else begin
            enabled = osc_run;
            if (enabled) begin
                drv_d.piezo_pos = osc_q; // R2 R9
            end
        end
        if (enabled) begin
            drv_d.piezo_neg = ~drv_d.piezo_pos; // R7
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            drv_q <= '0;
        end else begin
            drv_q <= drv_d;
        end
    end

    assign boost_en_out      = drv_q.boost_en;
    assign piezo_out_pos_out = drv_q.piezo_pos;
    assign piezo_out_neg_out = drv_q.piezo_neg;
    assign led_sink_pin_out  = drv_q.led_sink_en;
    assign self_drive_out    = ~mode_ext;

    // Checks
    sequence first_edge_s;
        tone_rise && state_q == piezo_pkg::ST_SHUTDOWN;
    endsequence
    sequence second_edge_s;
        mode_ext && state_q == piezo_pkg::ST_BOOST && tone_rise;
    endsequence
    sequence ext_on_s;
        mode_ext && $past(mode_ext) && state_q == piezo_pkg::ST_ACTIVE;
    endsequence
    sequence self_on_s;
        !mode_ext && !$past(mode_ext) && $past(osc_run);
    endsequence
    sequence idle_low_s;
        idle_q && both_low;
    endsequence

    disabled_low_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R4
        state_q == piezo_pkg::ST_SHUTDOWN |-> !piezo_out_pos_out && !piezo_out_neg_out)
        else $error("piezo outputs driven in shutdown");
    first_edge_boost_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R3
        first_edge_s |=> boost_en_out && !piezo_out_pos_out && !piezo_out_neg_out)
        else $error("first edge did not only start boost");
    second_edge_on_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R6
        second_edge_s |=> piezo_out_pos_out && !piezo_out_neg_out)
        else $error("second edge did not enable outputs");
    diff_pair_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R7
        piezo_out_pos_out |-> !piezo_out_neg_out)
        else $error("outputs not complementary");
    led_follow_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R10
        ##1 led_sink_pin_out == $past(led_s))
        else $error("led sink does not follow control");
    boost_on_input_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R11
        led_s |=> boost_en_out)
        else $error("boost off with led input high");
    idle_shutdown_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R8
        idle_low_s |=> !boost_en_out)
        else $error("no shutdown after idle");
    self_stop_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R9
        !mode_ext && !tone_s |=> !piezo_out_pos_out && !piezo_out_neg_out)
        else $error("self drive output with tone low");
    steady_high_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R5
        mode_ext && state_q == piezo_pkg::ST_BOOST && tone_s && !tone_rise
        |=> state_q != piezo_pkg::ST_ACTIVE)
        else $error("steady high enabled outputs");

    // External drive outputs
    ext_pair_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R7
        ext_on_s |-> piezo_out_neg_out == !piezo_out_pos_out)
        else $error("external drive outputs not complementary");
    ext_follow_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R6
        ext_on_s |-> piezo_out_pos_out == $past(tone_s))
        else $error("positive output does not follow tone");
    ext_off_low_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R4
        $past(mode_ext) && state_q != piezo_pkg::ST_ACTIVE
        |-> !piezo_out_pos_out && !piezo_out_neg_out)
        else $error("external drive outputs high while disabled");

    // Self drive outputs
    self_pair_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R7
        self_on_s |-> piezo_out_neg_out == !piezo_out_pos_out)
        else $error("self drive outputs not complementary");
    self_follow_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R9
        self_on_s |-> piezo_out_pos_out == $past(osc_q))
        else $error("positive output does not follow oscillator");
    self_off_low_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R4
        !$past(mode_ext) && !$past(osc_run) |-> !piezo_out_pos_out && !piezo_out_neg_out)
        else $error("self drive outputs high while stopped");
    self_no_step_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R2
        !mode_ext && state_q != piezo_pkg::ST_ACTIVE |=> state_q != piezo_pkg::ST_ACTIVE)
        else $error("self drive advanced on tone edge");
    osc_stop_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R9
        !osc_run |=> !osc_q)
        else $error("oscillator output high while stopped");

    // Power sequencing
    tone_keeps_boost_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R5
        tone_s |=> boost_en_out)
        else $error("boost off with tone input high");
    wake_led_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R11
        state_q == piezo_pkg::ST_SHUTDOWN && led_s |=> state_q == piezo_pkg::ST_BOOST)
        else $error("led input did not wake the boost");
    no_skip_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R13
        state_q == piezo_pkg::ST_SHUTDOWN |=> state_q != piezo_pkg::ST_ACTIVE)
        else $error("outputs enabled straight from shutdown");
    idle_hold_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R8
        !idle_q && state_q != piezo_pkg::ST_SHUTDOWN |=> boost_en_out)
        else $error("boost dropped before idle span");
endmodule
`default_nettype wire

// file: core/piezo_pkg.sv
// Package: constants and carrier types for the piezo and LED driver control
package piezo_pkg;
    localparam int unsigned CLK_FREQ_HZ       = 100_000_000;
    localparam int unsigned IDLE_TIME_MS      = 15;
    localparam int unsigned IDLE_CYCLES       = CLK_FREQ_HZ / 1000 * IDLE_TIME_MS;
    localparam int unsigned IDLE_CNT_W        = 21;
    localparam int unsigned OSC_HALF_DEFAULT  = 12500;
    localparam int unsigned OSC_CNT_W         = 20;
    localparam int unsigned LOW_MAJ_W         = 4;
    localparam logic [3:0]  LOW_MAJ_WINDOW    = 4'hF;
    localparam logic [3:0]  LOW_MAJ_THRESH    = 4'h8;
    localparam logic [1:0]  SYNC_RESET        = 2'h0;

    typedef enum logic [2:0] {
        ST_SHUTDOWN = 3'b001,
        ST_BOOST    = 3'b010,
        ST_ACTIVE   = 3'b100
    } seq_state_e;

    typedef struct packed {
        logic boost_en;
        logic piezo_pos;
        logic piezo_neg;
        logic led_sink_en;
    } drive_s;
endpackage

// file: verification/host_drive.sv
// Host model that drives the tone, LED control and oscillator resistor pins
`timescale 1ns/10ps
`default_nettype none
module host_drive (
    input  wire logic clock_in, // Bench clock
    output logic      tone_out, // Tone pin level
    output logic      led_out,  // LED control pin level
    output logic      mode_out  // Oscillator resistor pin, high for external drive
);
    initial begin
        tone_out = 1'b0;
        led_out  = 1'b0;
        mode_out = 1'b1;
    end
    // Pins change 1 ns after an edge and hold for the given number of cycles
    task automatic drive(input logic tone, input logic led, input int cycles);
        @(posedge clock_in);
        #1;
        tone_out = tone;
        led_out  = led;
        repeat (cycles - 1) @(posedge clock_in);
        #1;
    endtask
    task automatic set_mode(input logic ext);
        @(posedge clock_in);
        #1;
        mode_out = ext;
    endtask
endmodule
`default_nettype wire

// file: verification/piezo_led_driver_control_test.sv
// Self-checking bench for the piezo and LED driver control
`timescale 1ns/10ps
`default_nettype none
module piezo_led_driver_control_test;
    localparam int unsigned IDLE = 320;
    localparam int unsigned HALF = 4;
    logic clock_in, rst_n_in, tone, led, mode, boost, pos, neg, sink, self_drv, t, l;
    int   bad_count, checks, n;
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    host_drive host_u (.clock_in(clock_in), .tone_out(tone), .led_out(led), .mode_out(mode));
    piezo_led_driver_control #(.IDLE_CYCLES(IDLE), .OSC_HALF(HALF)) dut_u (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .tone_in(tone), .led_ctrl_in(led),
        .osc_resistor_pin_in(mode), .boost_en_out(boost), .piezo_out_pos_out(pos),
        .piezo_out_neg_out(neg), .led_sink_pin_out(sink), .self_drive_out(self_drv));
    function automatic logic boost_of(input logic tn, input logic ld);
        return tn | ld;
    endfunction
    task automatic chk(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Both pins low: still on at half the idle span, off within the span plus slack
    task automatic go_idle();
        int k;
        host_u.drive(1'b0, 1'b0, IDLE / 2);
        chk(boost, 1'b1);
        k = 0;
        while (boost !== 1'b0 && k < IDLE + 64) begin
            @(posedge clock_in);
            #1;
            k++;
        end
        chk(boost, 1'b0);
        chk(pos, 1'b0);
        chk(neg, 1'b0);
    endtask
    // Cycles between two changes of the positive output
    task automatic half_period(output int cnt);
        logic p0;
        p0 = pos;
        cnt = 0;
        while (pos === p0 && cnt < 100) begin
            @(posedge clock_in);
            #1;
            cnt++;
        end
        p0 = pos;
        cnt = 0;
        while (pos === p0 && cnt < 100) begin
            chk(neg, ~pos);
            @(posedge clock_in);
            #1;
            cnt++;
        end
    endtask
    initial begin
        #1_000_000;
        bad_count++;
        summarize();
    end
    initial begin
        bad_count = 0;
        checks = 0;
        rst_n_in = 1'b0;
        void'($urandom(32'h19491587));
        repeat (5) @(posedge clock_in);
        #1;
        rst_n_in = 1'b1;
        host_u.drive(1'b0, 1'b0, 6);
        chk(boost, 1'b0);
        chk(pos, 1'b0);
        chk(self_drv, 1'b0);
        host_u.drive(1'b1, 1'b0, 30);
        chk(boost, 1'b1);
        chk(pos, 1'b0);
        chk(neg, 1'b0);
        host_u.drive(1'b0, 1'b0, 6);
        chk(pos, 1'b0);
        host_u.drive(1'b1, 1'b0, 6);
        chk(pos, 1'b1);
        chk(neg, 1'b0);
        for (int i = 0; i < 40; i++) begin
            t = 1'($urandom_range(0, 1));
            l = 1'($urandom_range(0, 1));
            host_u.drive(t, l, int'($urandom_range(6, 12)));
            chk(pos, t);
            chk(neg, ~t);
            chk(sink, l);
            if (boost_of(t, l)) chk(boost, 1'b1);
        end
        go_idle();
        host_u.drive(1'b1, 1'b0, 6);
        chk(boost, 1'b1);
        chk(pos, 1'b0);
        go_idle();
        host_u.drive(1'b0, 1'b1, 6);
        chk(boost, 1'b1);
        chk(sink, 1'b1);
        chk(pos, 1'b0);
        host_u.drive(1'b0, 1'b0, 6);
        chk(sink, 1'b0);
        go_idle();
        host_u.set_mode(1'b0);
        host_u.drive(1'b0, 1'b0, 6);
        chk(self_drv, 1'b1);
        host_u.drive(1'b1, 1'b0, 10);
        for (int i = 0; i < 3; i++) begin
            half_period(n);
            chk(logic'(n == HALF), 1'b1);
            chk(boost, 1'b1);
        end
        host_u.drive(1'b0, 1'b0, 8 + 2 * HALF);
        chk(pos, 1'b0);
        chk(neg, 1'b0);
        host_u.set_mode(1'b1);
        host_u.drive(1'b1, 1'b0, 6);
        chk(pos, 1'b1);
        chk(neg, 1'b0);
        @(posedge clock_in);
        #1;
        rst_n_in = 1'b0;
        #1;
        chk(boost, 1'b0);
        chk(pos, 1'b0);
        repeat (2) @(posedge clock_in);
        #1;
        rst_n_in = 1'b1;
        host_u.drive(1'b1, 1'b0, 6);
        chk(boost, 1'b1);
        chk(pos, 1'b0);
        chk(neg, 1'b0);
        summarize();
    end
endmodule
`default_nettype wire
